// *** logic/uebrf_bank.sv ***
// Interrupt endpoint gating, short-packet hold-off and RX FIFO levels
module uebrf_bank (
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    input  wire uebrf_pkg::uebrf_bus_req_t    bus,
    output logic [uebrf_pkg::DATA_W-1:0]      rdata,
    input  wire logic                         poll_tick,
    input  wire uebrf_pkg::uebrf_events_t     events,
    input  wire logic [uebrf_pkg::PIN_W-1:0]  pin_events,
    output logic                              int_packet_send,
    input  wire logic                         short_pkt_pending,
    output logic                              short_pkt_release,
    input  wire uebrf_pkg::uebrf_fifo_side_t  wr_side,
    input  wire uebrf_pkg::uebrf_fifo_side_t  rd_side
);
    import uebrf_pkg::*;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic                  always_send_status_packet_q;
    logic [EVT_W-1:0]      event_gates_q;
    logic [PIN_W-1:0]      pin_event_gates_q;
    logic [DLY_W-1:0]      hold_off_q;
    logic [LVL_W-1:0]      receive_read_level_q;
    logic [LVL_W-1:0]      receive_read_level_d;
    logic [LVL_W-1:0]      receive_write_level_q;
    logic [LVL_W-1:0]      receive_write_level_d;
    logic [LVL_W-1:0]      wr_pkt_cnt_q;
    logic [LVL_W-1:0]      rd_pkt_cnt_q;
    logic [LVL_W-1:0]      wr_pkt_total;
    logic [LVL_W-1:0]      rd_pkt_total;
    logic                  event_pending_q;
    logic                  gated_hit;
    logic [EVT_W-1:0]      event_vec;
    logic [DATA_W-1:0]     rd_word;
    logic                  wr_int_ep;

    wire logic mac_reset_timeout_gate  = event_gates_q[8];
    wire logic transmit_halted_gate    = event_gates_q[6];
    wire logic receive_halted_gate     = event_gates_q[5];
    wire logic line_interface_event_gate = event_gates_q[4];
    wire logic transmit_fault_gate     = event_gates_q[3];
    wire logic tx_buffer_underrun_gate = event_gates_q[2];
    wire logic tx_buffer_overrun_gate  = event_gates_q[1];
    wire logic dropped_frame_gate      = event_gates_q[0];

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    assign wr_int_ep = bus.wr && (bus.addr == OFS_INT_EP);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            always_send_status_packet_q <= INT_EP_RST[ALWAYS_BIT];
            event_gates_q               <= INT_EP_RST[EVT_LSB +: EVT_W];
            pin_event_gates_q           <= INT_EP_RST[PIN_W-1:0];
        end
        else if (wr_int_ep)
        begin
            always_send_status_packet_q <= bus.wdata[ALWAYS_BIT];
            event_gates_q               <= bus.wdata[EVT_LSB +: EVT_W];
            pin_event_gates_q           <= bus.wdata[PIN_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            hold_off_q <= DLY_RST;
        else if (bus.wr && (bus.addr == OFS_HOLD_OFF))
            hold_off_q <= bus.wdata[DLY_W-1:0];
    end

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    // Level register has no write path at all; writes there are dropped.
    always_comb
    begin
        rd_word = '0;
        if (bus.addr == OFS_INT_EP)
        begin
            rd_word[ALWAYS_BIT]           = always_send_status_packet_q;
            rd_word[EVT_LSB +: EVT_W]     = event_gates_q;
            rd_word[PIN_W-1:0]            = pin_event_gates_q;
        end
        else if (bus.addr == OFS_HOLD_OFF)
            rd_word[DLY_W-1:0] = hold_off_q;
        else if (bus.addr == OFS_FIFO_LVL)
        begin
            rd_word[RDLVL_LSB +: LVL_W] = receive_read_level_q;
            rd_word[WRLVL_LSB +: LVL_W] = receive_write_level_q;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rdata <= '0;
        else if (bus.rd)
            rdata <= rd_word;
        else
            rdata <= '0;
    end

    // ------------------------------------------------------------
    // Interrupt endpoint event gating
    // ------------------------------------------------------------
    assign event_vec = events;
    assign gated_hit = |(event_vec & event_gates_q)
                     | |(pin_events & pin_event_gates_q);

    // New event in the send cycle is kept for the next interval
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            event_pending_q <= 1'b0;
        else if (gated_hit)
            event_pending_q <= 1'b1;
        else if (poll_tick)
            event_pending_q <= 1'b0;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            int_packet_send <= 1'b0;
        else
            int_packet_send <= poll_tick
                && (always_send_status_packet_q
                    || event_pending_q);
    end

    // ------------------------------------------------------------
    // Short bulk-in packet hold-off
    // ------------------------------------------------------------
    uebrf_holdoff u_holdoff (
        .clk           (clk),
        .rst_b         (rst_b),
        .short_pending (short_pkt_pending),
        .delay_units   (hold_off_q),
        .short_release (short_pkt_release)
    );

    // ------------------------------------------------------------
    // Per-packet DWORD tallies
    // ------------------------------------------------------------
    // Totals include a DWORD moving in the same cycle as the packet end.
    assign wr_pkt_total = wr_pkt_cnt_q + LVL_W'(wr_side.dword);
    assign rd_pkt_total = rd_pkt_cnt_q + LVL_W'(rd_side.dword);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            wr_pkt_cnt_q <= '0;
        else if (wr_side.pkt_end || wr_side.rewind)
            wr_pkt_cnt_q <= '0;
        else
            wr_pkt_cnt_q <= wr_pkt_total;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rd_pkt_cnt_q <= '0;
        else if (rd_side.pkt_end || rd_side.rewind)
            rd_pkt_cnt_q <= '0;
        else
            rd_pkt_cnt_q <= rd_pkt_total;
    end

    // ------------------------------------------------------------
    // Level counters
    // ------------------------------------------------------------
    // Wrap is not guarded: the FIFO itself cannot hold more than fits.
    always_comb
    begin
        receive_read_level_d = receive_read_level_q;
        if (wr_side.pkt_end && !wr_side.rewind)
            receive_read_level_d = receive_read_level_d
                                 + wr_pkt_total;
        if (rd_side.dword)
            receive_read_level_d = receive_read_level_d - 1'b1;
        if (rd_side.rewind)
            receive_read_level_d = receive_read_level_d
                                 + rd_pkt_total;
    end

    always_comb
    begin
        receive_write_level_d = receive_write_level_q;
        if (wr_side.dword)
            receive_write_level_d = receive_write_level_d
                                  + 1'b1;
        if (rd_side.pkt_end && !rd_side.rewind)
            receive_write_level_d = receive_write_level_d
                                  - rd_pkt_total;
        if (wr_side.rewind)
            receive_write_level_d = receive_write_level_d
                                  - wr_pkt_total;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            receive_read_level_q  <= LVL_RST;
            receive_write_level_q <= LVL_RST;
        end
        else
        begin
            receive_read_level_q  <= receive_read_level_d;
            receive_write_level_q <= receive_write_level_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_always_on;
        always_send_status_packet_q && poll_tick |=> int_packet_send;
    endproperty
    a_always_on: assert property (p_always_on)
        else $error("always-on set but no packet at poll");

    property p_quiet_poll;
        !always_send_status_packet_q && !event_pending_q && poll_tick
            |=> !int_packet_send;
    endproperty
    a_quiet_poll: assert property (p_quiet_poll)
        else $error("packet sent with no enabled event");

    property p_event_gate;
        (|(event_vec & event_gates_q)) && !poll_tick
            ##1 poll_tick |=> int_packet_send;
    endproperty
    a_event_gate: assert property (p_event_gate)
        else $error("enabled core event did not raise a packet");

    property p_pin_gate;
        !event_pending_q && (|pin_events)
            && !(|(pin_events & pin_event_gates_q))
            && !(|(event_vec & event_gates_q)) |=> !event_pending_q;
    endproperty
    a_pin_gate: assert property (p_pin_gate)
        else $error("disabled pin event latched as pending");

    property p_delay_reset;
        $rose(rst_b) |-> hold_off_q == DLY_RST;
    endproperty
    a_delay_reset: assert property (@(posedge clk) p_delay_reset)
        else $error("hold-off field not at reset value");

    property p_read_commit;
        wr_side.pkt_end && !wr_side.rewind && !rd_side.dword && !rd_side.rewind
            |=> receive_read_level_q
                == $past(receive_read_level_q) + $past(wr_pkt_total);
    endproperty
    a_read_commit: assert property (p_read_commit)
        else $error("read level not raised by packet total");

    property p_read_dword;
        rd_side.dword && !rd_side.rewind && !wr_side.pkt_end
            |=> receive_read_level_q == $past(receive_read_level_q) - 1'b1;
    endproperty
    a_read_dword: assert property (p_read_dword)
        else $error("read level not decremented on DWORD read");

    property p_write_dword;
        wr_side.dword && !wr_side.rewind && !rd_side.pkt_end
            |=> receive_write_level_q == $past(receive_write_level_q) + 1'b1;
    endproperty
    a_write_dword: assert property (p_write_dword)
        else $error("write level not incremented on DWORD write");

    property p_write_rewind;
        wr_side.rewind && !rd_side.pkt_end
            |=> receive_write_level_q
                == $past(receive_write_level_q) - $past(wr_pkt_cnt_q);
    endproperty
    a_write_rewind: assert property (p_write_rewind)
        else $error("write rewind did not remove partial packet");

    property p_level_ro;
        bus.wr && bus.addr == OFS_FIFO_LVL && !wr_side.dword
            && !wr_side.pkt_end && !wr_side.rewind && !rd_side.dword
            && !rd_side.pkt_end && !rd_side.rewind
            |=> $stable(receive_read_level_q)
                && $stable(receive_write_level_q);
    endproperty
    a_level_ro: assert property (p_level_ro)
        else $error("software write changed a level counter");

    property p_send_on_poll;
        int_packet_send |-> $past(poll_tick);
    endproperty
    a_send_on_poll: assert property (p_send_on_poll)
        else $error("interrupt packet sent outside a polling interval");

    property p_event_latch;
        gated_hit |=> event_pending_q;
    endproperty
    a_event_latch: assert property (p_event_latch)
        else $error("enabled event not kept pending");

    property p_hold_write;
        bus.wr && bus.addr == OFS_HOLD_OFF
            |=> hold_off_q == $past(bus.wdata[DLY_W-1:0]);
    endproperty
    a_hold_write: assert property (p_hold_write)
        else $error("hold-off field did not take the written value");

    property p_read_rewind;
        rd_side.rewind && !wr_side.pkt_end
            |=> receive_read_level_q
                == $past(receive_read_level_q) + $past(rd_pkt_cnt_q);
    endproperty
    a_read_rewind: assert property (p_read_rewind)
        else $error("read rewind did not add back DWORDs read");

    property p_write_release;
        rd_side.pkt_end && !rd_side.rewind && !wr_side.dword && !wr_side.rewind
            |=> receive_write_level_q
                == $past(receive_write_level_q) - $past(rd_pkt_total);
    endproperty
    a_write_release: assert property (p_write_release)
        else $error("write level not lowered by packet read out");

    c_event_packet: cover property (event_pending_q && poll_tick);
    c_read_rewind:  cover property (rd_side.rewind && rd_pkt_cnt_q != '0);
    c_write_rewind: cover property (wr_side.rewind && wr_pkt_cnt_q != '0);
    c_full_packet:  cover property (wr_side.pkt_end ##[1:50] rd_side.pkt_end);

endmodule : uebrf_bank

// *** logic/uebrf_pkg.sv ***
// Shared constants and carrier types for the endpoint/level register bank
package uebrf_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam int             ADDR_W        = 8;
    localparam int             DATA_W        = 32;
    localparam logic [7:0]     OFS_INT_EP    = 8'h68;
    localparam logic [7:0]     OFS_HOLD_OFF  = 8'h6C;
    localparam logic [7:0]     OFS_FIFO_LVL  = 8'h70;

    // ------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------
    localparam int             ALWAYS_BIT    = 31;
    localparam int             EVT_LSB       = 11;
    localparam int             EVT_W         = 9;
    localparam int             PIN_W         = 11;
    localparam int             DLY_W         = 16;
    localparam int             LVL_W         = 14;
    localparam int             RDLVL_LSB     = 16;
    localparam int             WRLVL_LSB     = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0]    DLY_RST       = 16'h0800;
    localparam logic [31:0]    INT_EP_RST    = 32'h0000_0000;
    localparam logic [13:0]    LVL_RST       = 14'h0000;

    // ------------------------------------------------------------
    // Timing: one delay unit against the clock period
    // ------------------------------------------------------------
    localparam real            HOLD_UNIT_NS  = 16.667;
    localparam real            CLK_PERIOD_NS = 10.0;
    localparam int             ACC_W         = 16;
    localparam logic [15:0]    UNIT_PS       = 16'(int'(HOLD_UNIT_NS * 1000.0));
    localparam logic [15:0]    CLK_PS        = 16'(int'(CLK_PERIOD_NS * 1000.0));

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } uebrf_bus_req_t;

    // Field order matches enable bits 19 down to 11
    typedef struct packed {
        logic mac_reset_timeout;
        logic rx_fifo_has_frame;
        logic transmit_halted;
        logic receive_halted;
        logic line_interface;
        logic transmit_fault;
        logic tx_buffer_underrun;
        logic tx_buffer_overrun;
        logic dropped_frame;
    } uebrf_events_t;

    typedef struct packed {
        logic dword;
        logic pkt_end;
        logic rewind;
    } uebrf_fifo_side_t;

endpackage : uebrf_pkg

// *** logic/uebrf_holdoff.sv ***
// Short bulk-in packet hold-off timer with fractional unit divider
module uebrf_holdoff (
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    input  wire logic                       short_pending,
    input  wire logic [uebrf_pkg::DLY_W-1:0] delay_units,
    output logic                            short_release
);
    import uebrf_pkg::*;

    typedef enum logic [2:0] {
        HO_IDLE = 3'b001,
        HO_WAIT = 3'b010,
        HO_DONE = 3'b100
    } uebrf_ho_state_t;

    uebrf_ho_state_t   state_q;
    logic [ACC_W-1:0]  acc_q;
    logic [ACC_W:0]    acc_sum;
    logic              tick;
    logic [DLY_W-1:0]  cnt_q;
    logic              pend_q;
    logic              new_pkt;

    // ------------------------------------------------------------
    // Unit divider
    // ------------------------------------------------------------
    // Unit is not a whole number of cycles; accumulate picoseconds so
    // the average tick rate matches the unit without drift.
    assign acc_sum = {1'b0, acc_q} + {1'b0, CLK_PS};
    assign tick    = (acc_sum >= {1'b0, UNIT_PS});

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            acc_q <= '0;
        else if (tick)
            acc_q <= ACC_W'(acc_sum - {1'b0, UNIT_PS});
        else
            acc_q <= acc_sum[ACC_W-1:0];
    end

    // ------------------------------------------------------------
    // Hold-off sequence
    // ------------------------------------------------------------
    assign new_pkt = short_pending && !pend_q;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            pend_q <= 1'b0;
        else
            pend_q <= short_pending;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q       <= HO_IDLE;
            cnt_q         <= '0;
            short_release <= 1'b0;
        end
        else
        begin
            short_release <= 1'b0;
            if (new_pkt)
            begin
                state_q <= HO_WAIT;
                cnt_q   <= delay_units;
            end
            else
            begin
                case (state_q)
                    HO_WAIT:
                        if (!short_pending)
                            state_q <= HO_IDLE;
                        else if (cnt_q == '0)
                        begin
                            short_release <= 1'b1;
                            state_q       <= HO_DONE;
                        end
                        else if (tick)
                            cnt_q <= cnt_q - 1'b1;
                    HO_DONE:
                        if (!short_pending)
                            state_q <= HO_IDLE;
                    default:
                        state_q <= HO_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_hold_load;
        @(posedge clk) disable iff (!rst_b)
        new_pkt |=> (state_q == HO_WAIT) && (cnt_q == $past(delay_units));
    endproperty
    a_hold_load: assert property (p_hold_load)
        else $error("hold-off did not reload on new short packet");

    property p_hold_early;
        @(posedge clk) disable iff (!rst_b)
        short_release |-> $past(state_q == HO_WAIT) && $past(cnt_q) == '0;
    endproperty
    a_hold_early: assert property (p_hold_early)
        else $error("short packet released before delay expired");

    c_hold_release: cover property (@(posedge clk) disable iff (!rst_b)
        short_release);

endmodule : uebrf_holdoff

// *** verif/uebrf_host_model.sv ***
// Host-side partner: polls the interrupt endpoint, queues short packets
module uebrf_host_model (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic poll_req,
    input  wire logic short_req,
    input  wire logic int_packet_send,
    input  wire logic short_pkt_release,
    output logic      poll_tick,
    output logic      short_pkt_pending,
    output int        sends
);
    timeunit 1ns;
    timeprecision 1ps;

    // One polling interval per bench request
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            poll_tick <= 1'b0;
        else
            poll_tick <= poll_req;

    // Packet waits until let go; dropping it early would cancel it
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            short_pkt_pending <= 1'b0;
        else if (short_pkt_release === 1'b1)
            short_pkt_pending <= 1'b0;
        else if (short_req)
            short_pkt_pending <= 1'b1;

    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            sends <= 0;
        else if (int_packet_send === 1'b1)
            sends <= sends + 1;
endmodule : uebrf_host_model

// *** verif/uebrf_bank_tb.sv ***
// Self-checking bench for the endpoint and FIFO level register bank
module uebrf_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import uebrf_pkg::*;

    logic             clk, rst_b, poll_tick, poll_req, short_req;
    logic             pend, rel, send;
    logic [31:0]      rdata;
    logic [10:0]      pin_events;
    uebrf_bus_req_t   bus;
    uebrf_events_t    events;
    uebrf_fifo_side_t wr_side, rd_side;
    int               sends, err_total, checked;

    uebrf_bank dut (.clk(clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
        .poll_tick(poll_tick), .events(events), .pin_events(pin_events),
        .int_packet_send(send), .short_pkt_pending(pend),
        .short_pkt_release(rel), .wr_side(wr_side), .rd_side(rd_side));

    uebrf_host_model host (.clk(clk), .rst_b(rst_b), .poll_req(poll_req),
        .short_req(short_req), .int_packet_send(send),
        .short_pkt_release(rel), .poll_tick(poll_tick),
        .short_pkt_pending(pend), .sends(sends));

    task automatic chk(input logic [31:0] g, input logic [31:0] e,
                       input string w);
        checked++;
        if (g !== e)
        begin
            err_total++;
            $display("wrong value at %0t: %s %h/%h", $time, w, g, e);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                          input string w);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 chk(rdata, e, w);
    endtask : rd_chk

    // Send count is read two edges after the answer is due
    task automatic poll_chk(input int e, input string w);
        int b;
        b = sends;
        @(posedge clk);
        poll_req <= 1'b1;
        @(posedge clk);
        poll_req <= 1'b0;
        repeat (3) @(posedge clk);
        chk(32'(sends - b), 32'(e), w);
    endtask : poll_chk

    task automatic fire(input logic [19:0] v);
        @(posedge clk);
        events <= v[19:11];
        pin_events <= v[10:0];
        @(posedge clk);
        events <= 9'h0;
        pin_events <= 11'h0;
    endtask : fire

    task automatic push(input logic ws, input logic [2:0] v, input int n);
        repeat (n)
        begin
            @(posedge clk);
            if (ws)
                wr_side <= v;
            else
                rd_side <= v;
            @(posedge clk);
            wr_side <= 3'h0;
            rd_side <= 3'h0;
        end
    endtask : push

    task automatic t_reset;
        rd_chk(OFS_HOLD_OFF, 32'h0000_0800, "hold rst");
        rd_chk(OFS_FIFO_LVL, 32'h0, "lvl rst");
        rd_chk(8'h74, 32'h0, "unmapped");
    endtask : t_reset

    task automatic t_always;
        wr_reg(OFS_INT_EP, 32'hFFFF_FFFF);
        rd_chk(OFS_INT_EP, 32'h800F_FFFF, "ctl rw");
        poll_chk(1, "always 1");
        poll_chk(1, "always 2");
        wr_reg(OFS_INT_EP, 32'h000F_FFFF);
        poll_chk(0, "no event");
    endtask : t_always

    task automatic t_gates;
        for (int i = 0; i < 20; i++)
        begin
            wr_reg(OFS_INT_EP, 32'h000F_FFFF ^ (32'h1 << i));
            fire(20'h1 << i);
            poll_chk(0, "gate shut");
            wr_reg(OFS_INT_EP, 32'h1 << i);
            fire(20'h1 << i);
            poll_chk(1, "gate open");
            poll_chk(0, "cleared");
        end
    endtask : t_gates

    // Event in the poll cycle waits for the next interval
    task automatic t_same;
        int b;
        wr_reg(OFS_INT_EP, 32'h0002_0000);
        b = sends;
        @(posedge clk);
        poll_req <= 1'b1;
        @(posedge clk);
        poll_req <= 1'b0;
        events <= 9'h040;
        @(posedge clk);
        events <= 9'h000;
        repeat (2) @(posedge clk);
        chk(32'(sends - b), 32'h0, "same poll");
        poll_chk(1, "next poll");
    endtask : t_same

    task automatic t_hold(input logic [15:0] d);
        int n, lo;
        lo = int'(d) * 5 / 3;
        n = 0;
        if (d != DLY_RST)
            wr_reg(OFS_HOLD_OFF, {16'hFFFF, d});
        rd_chk(OFS_HOLD_OFF, {16'h0, d}, "hold rw");
        @(posedge clk);
        short_req <= 1'b1;
        @(posedge clk);
        short_req <= 1'b0;
        while (rel !== 1'b1 && n < 5000)
        begin
            @(posedge clk);
            #1 n++;
        end
        chk(32'(n >= lo && n <= lo + 4), 32'h1, "hold time");
    endtask : t_hold

    task automatic t_levels;
        push(1'b1, 3'h4, 2);
        rd_chk(OFS_FIFO_LVL, {16'h0, 16'h2}, "wr part");
        push(1'b1, 3'h6, 1);
        rd_chk(OFS_FIFO_LVL, {16'h3, 16'h3}, "wr pkt");
        push(1'b0, 3'h4, 2);
        rd_chk(OFS_FIFO_LVL, {16'h1, 16'h3}, "rd part");
        push(1'b0, 3'h1, 1);
        rd_chk(OFS_FIFO_LVL, {16'h3, 16'h3}, "rd rewind");
        push(1'b0, 3'h4, 2);
        push(1'b0, 3'h6, 1);
        rd_chk(OFS_FIFO_LVL, {16'h0, 16'h0}, "rd pkt");
        push(1'b1, 3'h4, 2);
        push(1'b1, 3'h1, 1);
        rd_chk(OFS_FIFO_LVL, {16'h0, 16'h0}, "wr rewind");
        wr_reg(OFS_FIFO_LVL, 32'hFFFF_FFFF);
        rd_chk(OFS_FIFO_LVL, 32'h0, "lvl ro");
    endtask : t_levels

    // Reset in mid-run must clear levels and restore the hold-off
    task automatic t_rerun;
        push(1'b1, 3'h4, 1);
        wr_reg(OFS_HOLD_OFF, 32'h0000_0123);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
    endtask : t_rerun

    task automatic results;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // About 4k cycles are needed; the longest hold-off is 3.4k
    initial
    begin
        #400000;
        err_total++;
        results();
    end

    initial
    begin
        rst_b = 1'b0;
        bus = '0;
        events = '0;
        pin_events = 11'h0;
        wr_side = '0;
        rd_side = '0;
        poll_req = 1'b0;
        short_req = 1'b0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_always();
        t_gates();
        t_same();
        t_hold(DLY_RST);
        t_hold(16'h0030);
        t_hold(16'h0000);
        t_levels();
        t_rerun();
        results();
    end
endmodule : uebrf_bank_tb
